// [dram_ctrl_defs.vh]
// constants for the strobe-driven dram controller: timing counts and field layout
// assumes a 200 MHz core clock; counts are in core clock cycles
`ifndef DRAM_CTRL_DEFS_VH
`define DRAM_CTRL_DEFS_VH

`define CLK_PERIOD_PS      5000
`define POWERUP_PAUSE_US   500
// least time, rounded up to whole cycles
`define POWERUP_CYCLES     ((`POWERUP_PAUSE_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define INIT_CYCLE_COUNT   8
`define ADDR_BITS          8
`define ROW_LOW_BITS       7
// per-phase strobe times in ns, rounded up to cycles
`define RAS_PRECHARGE_NS   200
`define RAS_PRECHARGE_CYC  ((`RAS_PRECHARGE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RAS_TO_CAS_NS      60
`define RAS_TO_CAS_CYC     ((`RAS_TO_CAS_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CAS_ACCESS_NS      150
`define CAS_ACCESS_CYC     ((`CAS_ACCESS_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RAS_ACTIVE_NS      200
`define RAS_ACTIVE_CYC     ((`RAS_ACTIVE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// command codes on cmd
`define CMD_READ           3'h0
`define CMD_WRITE_EARLY    3'h1
`define CMD_WRITE_LATE     3'h2
`define CMD_REFRESH        3'h3
`define CMD_HIDDEN_REFRESH 3'h4

`endif

// [phase_timer.v]
// down-counter that times each strobe phase of the controller
// assumes load and count come from the same clock domain
`timescale 1ns/1ps
module phase_timer #(
    parameter W = 20
) (
    core_clk,
    rst,
    load,
    load_val,
    done
);
    input  wire         core_clk;  // core clock
    input  wire         rst;       // async reset, active high
    input  wire         load;      // restart the count
    input  wire [W-1:0] load_val;  // cycles to wait
    output wire         done;      // count reached zero

    reg [W-1:0] cnt_q;             // remaining cycles

    // load wins over counting so a new phase starts cleanly
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= {W{1'b0}};
        end else if (load) begin
            cnt_q <= load_val;
        end else if (cnt_q != {W{1'b0}}) begin
            cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign done = (cnt_q == {W{1'b0}}) && !load;
endmodule

// [dram_ctrl.v]
// controller for a 64k x 1 multiplexed-address dram: strobes, address, data pins
// assumes the dram sits on its pins directly; user side is a request/done handshake
`timescale 1ns/1ps
`include "dram_ctrl_defs.vh"
module dram_ctrl #(
    parameter POWERUP_CYCLES = `POWERUP_CYCLES
) (
    core_clk,
    rst,
    req,
    cmd,
    addr,
    wdata,
    busy,
    ready,
    done,
    rdata,
    ras_n,
    cas_n,
    we_n,
    dram_addr,
    din,
    dout
);
    input  wire        core_clk;   // 200 MHz core clock
    input  wire        rst;        // async reset, active high
    input  wire        req;        // request pulse, taken when busy low
    input  wire [2:0]  cmd;        // operation code
    input  wire [15:0] addr;       // row in [15:8], column in [7:0]
    input  wire        wdata;      // bit to write
    output reg         busy;       // controller occupied
    output reg         ready;      // init sequence finished
    output reg         done;       // one-cycle completion pulse
    output reg         rdata;      // last bit read
    output reg         ras_n;      // row strobe, active low
    output reg         cas_n;      // column strobe, active low
    output reg         we_n;       // write strobe, active low
    output reg  [7:0]  dram_addr;  // multiplexed address lines
    output reg         din;        // data input of the dram
    input  wire        dout;       // data output of the dram

    localparam TW = 20;
    // state codes
    localparam S_PAUSE   = 4'h0;
    localparam S_INIT_LO = 4'h1;
    localparam S_INIT_HI = 4'h2;
    localparam S_IDLE    = 4'h3;
    localparam S_RAS     = 4'h4;
    localparam S_CAS     = 4'h5;
    localparam S_LATE_WE = 4'h6;
    localparam S_PRECH   = 4'h7;
    localparam S_HID_HI  = 4'h8;
    localparam S_HID_LO  = 4'h9;

    reg  [3:0]    state_q;      // current state
    reg  [2:0]    cmd_q;        // latched operation
    reg  [15:0]   addr_q;       // latched address
    reg           wdata_q;      // latched write bit
    reg  [3:0]    init_cnt_q;   // init cycles issued
    reg           tmr_load;     // restart the phase timer
    reg  [31:0]   tmr_val;      // its count, cut to TW bits at the timer
    wire          tmr_done;     // phase time elapsed

    phase_timer #(.W(TW)) u_timer (
        .core_clk (core_clk),
        .rst      (rst),
        .load     (tmr_load),
        .load_val (tmr_val[TW-1:0]),
        .done     (tmr_done)
    );

    // one process owns all pins so strobe order is fixed per state
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q    <= S_PAUSE;
            cmd_q      <= 3'h0;
            addr_q     <= 16'h0000;
            wdata_q    <= 1'b0;
            init_cnt_q <= 4'h0;
            tmr_load   <= 1'b1;
            tmr_val    <= POWERUP_CYCLES;
            busy       <= 1'b1;
            ready      <= 1'b0;
            done       <= 1'b0;
            rdata      <= 1'b0;
            ras_n      <= 1'b1;  // deselected, output floats
            cas_n      <= 1'b1;
            we_n       <= 1'b1;
            dram_addr  <= 8'h00;
            din        <= 1'b0;
        end else begin
            tmr_load <= 1'b0;
            done     <= 1'b0;
            case (state_q)
                // power-up pause before any cycle
                S_PAUSE: begin
                    if (tmr_done) begin
                        state_q  <= S_INIT_LO;
                        ras_n    <= 1'b0;
                        tmr_load <= 1'b1;
                        tmr_val  <= `RAS_ACTIVE_CYC;
                    end
                end
                // eight ras-only wake-up cycles
                S_INIT_LO: begin
                    if (tmr_done) begin
                        ras_n      <= 1'b1;
                        init_cnt_q <= init_cnt_q + 4'h1;
                        state_q    <= S_INIT_HI;
                        tmr_load   <= 1'b1;
                        tmr_val    <= `RAS_PRECHARGE_CYC;
                    end
                end
                S_INIT_HI: begin
                    if (tmr_done) begin
                        if (init_cnt_q == `INIT_CYCLE_COUNT) begin
                            state_q <= S_IDLE;
                            ready   <= 1'b1;
                            busy    <= 1'b0;
                        end else begin
                            ras_n    <= 1'b0;
                            state_q  <= S_INIT_LO;
                            tmr_load <= 1'b1;
                            tmr_val  <= `RAS_ACTIVE_CYC;
                        end
                    end
                end
                // take a request and present the row
                S_IDLE: begin
                    if (req) begin
                        cmd_q   <= cmd;
                        addr_q  <= addr;
                        wdata_q <= wdata;
                        busy    <= 1'b1;
                        // hidden refresh keeps cas low from the previous read
                        if (cmd == `CMD_HIDDEN_REFRESH) begin
                            cas_n     <= 1'b0;
                            we_n      <= 1'b1;
                            dram_addr <= {1'b0, addr[14:8]};
                            state_q   <= S_HID_HI;
                        end else begin
                            // refresh row uses low seven bits only
                            dram_addr <= (cmd == `CMD_REFRESH) ? {1'b0, addr[14:8]} : addr[15:8];
                            // a read may have left cas low; raise it so the later column fall is a real edge
                            cas_n     <= 1'b1;
                            ras_n     <= 1'b0;
                            state_q   <= S_RAS;
                        end
                        tmr_load <= 1'b1;
                        tmr_val  <= `RAS_TO_CAS_CYC;
                    end
                end
                // row held, then column strobe unless refresh only
                S_RAS: begin
                    if (tmr_done) begin
                        tmr_load <= 1'b1;
                        if (cmd_q == `CMD_REFRESH) begin
                            cas_n   <= 1'b1;  // cas stays high
                            state_q <= S_PRECH;
                            tmr_val <= `RAS_ACTIVE_CYC;
                        end else begin
                            dram_addr <= addr_q[7:0];
                            din       <= wdata_q;  // stored as is
                            // early write: we goes low in the same cycle that cas falls
                            we_n      <= (cmd_q == `CMD_WRITE_EARLY) ? 1'b0 : 1'b1;
                            cas_n     <= 1'b0;  // read or write on all low
                            state_q   <= S_CAS;
                            tmr_val   <= `CAS_ACCESS_CYC;
                        end
                    end
                end
                // after access time sample data or strobe a late write
                S_CAS: begin
                    if (tmr_done) begin
                        if (cmd_q == `CMD_READ) begin
                            rdata <= dout;  // no inversion
                            state_q  <= S_PRECH;
                            tmr_load <= 1'b1;
                            tmr_val  <= `RAS_PRECHARGE_CYC;
                        end else if (cmd_q == `CMD_WRITE_LATE) begin
                            we_n     <= 1'b0;  // output may drive until cas rises
                            state_q  <= S_LATE_WE;
                            tmr_load <= 1'b1;
                            tmr_val  <= `CAS_ACCESS_CYC;
                        end else begin
                            state_q  <= S_PRECH;
                            tmr_load <= 1'b1;
                            tmr_val  <= `RAS_PRECHARGE_CYC;
                        end
                        ras_n <= (cmd_q == `CMD_WRITE_LATE) ? 1'b0 : 1'b1;
                        // a read leaves cas low so a hidden refresh may follow
                        cas_n <= (cmd_q == `CMD_READ) ? 1'b0 : (cmd_q == `CMD_WRITE_LATE) ? 1'b0 : 1'b1;
                        we_n  <= (cmd_q == `CMD_WRITE_LATE) ? 1'b0 : 1'b1;
                    end
                end
                // late write pulse done, release every strobe
                S_LATE_WE: begin
                    if (tmr_done) begin
                        ras_n    <= 1'b1;
                        cas_n    <= 1'b1;
                        we_n     <= 1'b1;
                        state_q  <= S_PRECH;
                        tmr_load <= 1'b1;
                        tmr_val  <= `RAS_PRECHARGE_CYC;
                    end
                end
                // ras precharge, then report completion
                S_PRECH: begin
                    if (tmr_done && !ras_n) begin
                        ras_n    <= 1'b1;  // end of ras-only refresh
                        tmr_load <= 1'b1;
                        tmr_val  <= `RAS_PRECHARGE_CYC;
                    end else if (tmr_done) begin
                        busy    <= 1'b0;
                        done    <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
                // hidden refresh: ras precharge high, cas held low
                S_HID_HI: begin
                    if (tmr_done) begin
                        ras_n    <= 1'b0;
                        state_q  <= S_HID_LO;
                        tmr_load <= 1'b1;
                        tmr_val  <= `RAS_ACTIVE_CYC;
                    end
                end
                S_HID_LO: begin
                    if (tmr_done) begin
                        ras_n    <= 1'b1;  // rdata keeps the last read bit
                        state_q  <= S_PRECH;
                        tmr_load <= 1'b1;
                        tmr_val  <= `RAS_PRECHARGE_CYC;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                    ras_n   <= 1'b1;
                    cas_n   <= 1'b1;
                    we_n    <= 1'b1;
                end
            endcase
        end
    end
endmodule

// [dram_ctrl_props.sv]
// pin checks on the dram controller: power-up, strobe order, read capture
// assumes it is bound to dram_ctrl and sees only its ports
`timescale 1ns/1ps
module dram_ctrl_props #(
    parameter POWERUP_CYCLES = 100000
) (
    input wire        core_clk,
    input wire        rst,
    input wire        req,
    input wire [2:0]  cmd,
    input wire [15:0] addr,
    input wire        wdata,
    input wire        busy,
    input wire        ready,
    input wire        done,
    input wire        rdata,
    input wire        ras_n,
    input wire        cas_n,
    input wire        we_n,
    input wire [7:0]  dram_addr,
    input wire        din,
    input wire        dout
);
    reg [31:0] cyc_q;  // cycles since reset, saturating
    reg [3:0]  fall_q; // row strobe falls before ready
    // count from reset release; saturation keeps a long run from wrapping
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cyc_q  <= 32'h0;
            fall_q <= 4'h0;
        end else begin
            if (cyc_q != 32'hffffffff) cyc_q <= cyc_q + 32'h1;
            if (!ready && $fell(ras_n)) fall_q <= fall_q + 4'h1;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    pause_wait_a: assert property (cyc_q + 32'h1 < POWERUP_CYCLES |-> ras_n)
        else $error("row strobe active during power-up pause");
    init_count_a: assert property ($rose(ready) |-> fall_q == 4'h8)
        else $error("ready without eight init cycles");
    init_busy_a: assert property (!ready |-> busy)
        else $error("not busy before ready");
    write_strobes_a: assert property ($fell(we_n) |-> !ras_n && !cas_n)
        else $error("write strobe outside active cycle");
    din_hold_a: assert property (!we_n && $past(we_n) == 1'b0 |-> $stable(din))
        else $error("data moved while writing");
    cas_after_ras_a: assert property ($fell(cas_n) |-> $past(ras_n, 11) == 1'b0)
        else $error("column strobe too soon after row strobe");
    read_capture_a: assert property ($changed(rdata) |-> $rose(ras_n) && !cas_n && we_n)
        else $error("read data changed outside read end");
    hidden_we_a: assert property ($fell(ras_n) && !cas_n |-> we_n)
        else $error("hidden refresh with write strobe low");
endmodule

// [dram_model.sv]
// behavioural 64k x 1 dram: strobe decoding, cell array, output inverted when released
// assumes ideal edges; cells never decay, so refresh only latches a row
`timescale 1ns/1ps
module dram_model #(
    parameter ACCESS_NS = 0
) (
    input wire       ras_n,     // row strobe
    input wire       cas_n,     // column strobe
    input wire       we_n,      // write strobe
    input wire [7:0] dram_addr, // multiplexed address
    input wire       din,       // data to store
    output reg       dout       // data out, inverted last value when floating
);
    reg        mem [0:65535]; // cell array
    reg [7:0]  row_q;         // row latched at row strobe fall
    reg [15:0] cell_q;        // addressed cell
    reg        drv_q;         // output driven
    initial begin
        dout  = 1'b0;
        drv_q = 1'b0;
    end
    // refresh needs no action here; only the low seven bits would pick the row
    always @(negedge ras_n) row_q <= dram_addr;
    // column fall: early write stores and floats, read drives the cell uninverted
    always @(negedge cas_n) begin
        if (!ras_n) begin
            cell_q = {row_q, dram_addr};
            if (!we_n) begin
                mem[cell_q] = din;
                if (drv_q) dout = ~dout;
                drv_q = 1'b0;
            end else begin
                dout <= #(ACCESS_NS) mem[cell_q];
                drv_q = 1'b1;
            end
        end
    end
    // late write stores, output keeps its read value
    // address taken from the pins: in an early write cell_q may not be updated yet
    always @(negedge we_n) if (!ras_n && !cas_n) mem[{row_q, dram_addr}] = din;
    // column rise releases the output; hidden refresh never touches it
    always @(posedge cas_n) begin
        if (drv_q) dout = ~dout;
        drv_q = 1'b0;
    end
endmodule

// [tb_top.sv]
// bench: controller against the dram model, expected bits kept in an associative array, written addresses in a queue
// assumes a shortened power-up pause and the controller's request/done handshake
`timescale 1ns/1ps
module tb_top;
    reg         core_clk = 1'b0;  // 200 MHz clock
    reg         rst      = 1'b1;  // async reset
    reg         req      = 1'b0;  // request
    reg  [2:0]  cmd      = 3'h0;  // op code
    reg  [15:0] addr     = 16'h0; // cell address
    reg         wdata    = 1'b0;  // bit to write
    wire        busy, ready, done, rdata, ras_n, cas_n, we_n, din, dout;
    wire [7:0]  dram_addr;
    integer     fail_count = 0;   // mismatches
    integer     checks     = 0;   // comparisons
    integer     i, k;
    reg  [15:0] a;
    bit         exp_mem [int];    // expected cell contents
    int         wq [$];           // written addresses
    always #2.5 core_clk = ~core_clk;
    dram_ctrl #(.POWERUP_CYCLES(20)) dram_ctrl_i (.core_clk(core_clk), .rst(rst), .req(req),
        .cmd(cmd), .addr(addr), .wdata(wdata), .busy(busy), .ready(ready), .done(done),
        .rdata(rdata), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .dram_addr(dram_addr),
        .din(din), .dout(dout));
    // slow answer, still inside the controller's sampling point
    dram_model #(.ACCESS_NS(120)) dram_model_i (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .dram_addr(dram_addr), .din(din), .dout(dout));
    task results;
        begin
            $display("checks %0d mismatches %0d", checks, fail_count);
            if (fail_count == 0 && checks > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    task cmp(input logic got, input logic exp, input string what);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
            end
        end
    endtask
    // one request, then a bounded wait for the done pulse
    task do_op(input [2:0] c, input [15:0] ad, input w);
        integer n;
        begin
            cmd = c;
            addr = ad;
            wdata = w;
            req = 1'b1;
            @(posedge core_clk);
            #1 req = 1'b0;
            n = 0;
            while (done !== 1'b1 && n < 1000) begin
                @(posedge core_clk);
                #1 n = n + 1;
            end
            if (done !== 1'b1) begin
                fail_count = fail_count + 1;
                $display("unexpected at %0t: no done", $time);
                results;
            end
        end
    endtask
    initial begin
        k = $urandom(80);
        repeat (4) @(posedge core_clk);
        #1 rst = 1'b0;
        k = 0;
        while (ready !== 1'b1 && k < 2000) begin
            @(posedge core_clk);
            #1 k = k + 1;
        end
        cmp(ready, 1'b1, "ready");
        cmp(busy, 1'b0, "busy");
        // a missing ready was counted above; stop here
        if (ready !== 1'b1) results;
        // early and late writes in turn; repeated cells just overwrite
        for (i = 0; i < 16; i = i + 1) begin
            a = 16'($urandom);
            exp_mem[a] = 1'($urandom);
            wq.push_back(a);
            do_op((i % 2) ? 3'h2 : 3'h1, a, exp_mem[a]);
        end
        // row-only refresh anywhere, top bit included; cells must survive
        for (i = 0; i < 4; i = i + 1) do_op(3'h3, 16'($urandom), 1'($urandom));
        // read back, then a hidden refresh must leave data and output alone
        foreach (wq[j]) begin
            do_op(3'h0, wq[j][15:0], 1'($urandom));
            cmp(rdata, exp_mem[wq[j]], "read");
            do_op(3'h4, 16'($urandom), 1'($urandom));
            cmp(rdata, exp_mem[wq[j]], "hidden rdata");
            cmp(dout, exp_mem[wq[j]], "hidden dout");
        end
        results;
    end
endmodule
bind dram_ctrl dram_ctrl_props #(.POWERUP_CYCLES(POWERUP_CYCLES)) dram_ctrl_props_i (
    .core_clk(core_clk), .rst(rst), .req(req), .cmd(cmd), .addr(addr), .wdata(wdata),
    .busy(busy), .ready(ready), .done(done), .rdata(rdata), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .dram_addr(dram_addr), .din(din), .dout(dout));
